/* File: irq_map_pkg.sv */
/*
  Package for the interrupt vector map: IRQ numbers, vector addresses,
  wake masks per low-power mode, and the request/answer carriers.
  Assumes a single 200 MHz system clock domain.
*/
package irq_map_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int NUM_IRQ = 19;
  localparam int IRQ_W = 5;
  localparam int VEC_W = 24;

  // ------------------------------------------------------------------
  // Vector addresses
  // ------------------------------------------------------------------
  localparam logic [VEC_W-1:0] RESET_VECTOR = 24'h008000;
  localparam logic [VEC_W-1:0] TRAP_VECTOR = 24'h008004;
  localparam logic [VEC_W-1:0] IRQ_VECTOR_BASE = 24'h008008;
  localparam logic [VEC_W-1:0] VECTOR_STEP = 24'h000004;

  // ------------------------------------------------------------------
  // IRQ numbers
  // ------------------------------------------------------------------
  localparam logic [IRQ_W-1:0] IRQ_TOP_LEVEL = 5'h00;
  localparam logic [IRQ_W-1:0] IRQ_FLASH = 5'h01;
  localparam logic [IRQ_W-1:0] IRQ_DMA01 = 5'h02;
  localparam logic [IRQ_W-1:0] IRQ_DMA23 = 5'h03;
  localparam logic [IRQ_W-1:0] IRQ_RTC = 5'h04;
  localparam logic [IRQ_W-1:0] IRQ_VOLTAGE = 5'h05;
  localparam logic [IRQ_W-1:0] IRQ_PORT_B = 5'h06;
  localparam logic [IRQ_W-1:0] IRQ_PORT_D = 5'h07;
  localparam logic [IRQ_W-1:0] IRQ_LINE0 = 5'h08;
  localparam logic [IRQ_W-1:0] IRQ_RESERVED = 5'h10;
  localparam logic [IRQ_W-1:0] IRQ_CLOCK = 5'h11;
  localparam logic [IRQ_W-1:0] IRQ_ADC = 5'h12;

  // ------------------------------------------------------------------
  // Wake masks, bit n = IRQ n
  // ------------------------------------------------------------------
  localparam logic [NUM_IRQ-1:0] WAKE_HALT_MASK = 19'h4fff0;
  localparam logic [NUM_IRQ-1:0] WAKE_ACTIVE_HALT_MASK = 19'h4fff0;
  localparam logic [NUM_IRQ-1:0] WAKE_INT_WAIT_MASK = 19'h6fffe;
  localparam logic [NUM_IRQ-1:0] WAKE_EVT_WAIT_MASK = 19'h6fffe;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_RUN = 3'b000,
    MODE_HALT = 3'b001,
    MODE_ACTIVE_HALT = 3'b010,
    MODE_INT_WAIT = 3'b011,
    MODE_EVT_WAIT = 3'b100
  } power_mode_t;

  typedef struct packed {
    logic flashIrq;
    logic [3:0] dmaUnitOneIrq;
    logic rtcAlarmA;
    logic rtcWakeup;
    logic [2:0] rtcTamper;
    logic voltageDetectorIrq;
    logic portBPinIrq;
    logic portDPinIrq;
    logic [7:0] extLineIrq;
    logic clockSwitchIrq;
    logic clockSecurityFault;
    logic adcUnitOneIrq;
  } src_req_t;

  typedef struct packed {
    logic valid;
    logic [IRQ_W-1:0] irqNum;
    logic [VEC_W-1:0] vector;
  } vec_out_t;

endpackage : irq_map_pkg

/* File: irq_priority_pick.sv */
/*
  Fixed-order picker: lowest-numbered pending request wins.
  Assumes purely combinational use by the vector map.
*/
`timescale 1ns/10ps
module irq_priority_pick (
  input wire logic [irq_map_pkg::NUM_IRQ-1:0] pending,
  output logic found,
  output logic [irq_map_pkg::IRQ_W-1:0] winner
);

  // Scan downward so the lowest index is written last and wins
  always_comb begin
    found = 1'b0;
    winner = '0;
    for (int i = irq_map_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (pending[i]) begin
        found = 1'b1;
        winner = irq_map_pkg::IRQ_W'(i);
      end
    end
  end

endmodule : irq_priority_pick

/* File: interrupt_vector_map.sv */
/*
  Interrupt vector map: gathers peripheral requests into IRQ lines,
  picks the one to present to the core, gives its vector, and flags
  wakeup from the current low-power mode.
  Assumes requests are levels from logic on clk; the core holds
  irqEnable stable and pulses vecTaken when it fetches the vector.
*/
`timescale 1ns/10ps

// Notes on behaviour
// - Reset vector 0x008000 wakes all modes; trap vector 0x008004 wakes none.
// - Top-level interrupt is IRQ 0 at 0x008008; wakes no low-power mode.
// - Flash request is IRQ 1 at 0x00800C; wakes only the two wait modes.
// - DMA channels 0/1 share IRQ 2 at 0x008010; wake only wait modes.
// - DMA channels 2/3 share IRQ 3 at 0x008014; wake only wait modes.
// - Clock alarm/wakeup/tamper IRQ 4, voltage IRQ 5; both wake all modes.
// - Port B pin IRQ 6, port D pin IRQ 7; wake all modes.
// - Lines 0..7 are IRQ 8..15, vectors 0x008028..0x008044; wake all.
// - Clock controller request is IRQ 17 at 0x00804C; wakes wait modes only.
// - Converter request is IRQ 18 at 0x008050; wakes halt and wait modes.
// - In event wait, serve enabled interrupts then return; wake events resume.
// - Top-level request is OR of the two timer overflow interrupts.
module interrupt_vector_map (
  input wire logic clk,
  input wire logic sys_rst,
  input wire irq_map_pkg::src_req_t srcReq,
  input wire logic generalTimerAOverflow,
  input wire logic basicEightBitTimerOverflow,
  input wire logic [irq_map_pkg::NUM_IRQ-1:0] irqEnable,
  input wire logic [irq_map_pkg::NUM_IRQ-1:0] wakeEventCfg,
  input wire irq_map_pkg::power_mode_t powerMode,
  input wire logic vecTaken,
  output irq_map_pkg::vec_out_t vecOut,
  output logic [irq_map_pkg::NUM_IRQ-1:0] irqPending,
  output logic wakeReq,
  output logic resumeReq,
  output logic returnToEventWait,
  output logic [irq_map_pkg::VEC_W-1:0] resetVector,
  output logic [irq_map_pkg::VEC_W-1:0] trapVector
);

  // ------------------------------------------------------------------
  // Request gathering
  // ------------------------------------------------------------------
  logic [irq_map_pkg::NUM_IRQ-1:0] rawIrq;
  logic topLevelIrq;

  assign topLevelIrq = generalTimerAOverflow | basicEightBitTimerOverflow;

  always_comb begin
    rawIrq = '0;
    rawIrq[irq_map_pkg::IRQ_TOP_LEVEL] = topLevelIrq;
    rawIrq[irq_map_pkg::IRQ_FLASH] = srcReq.flashIrq;
    rawIrq[irq_map_pkg::IRQ_DMA01] = |srcReq.dmaUnitOneIrq[1:0];
    rawIrq[irq_map_pkg::IRQ_DMA23] = |srcReq.dmaUnitOneIrq[3:2];
    rawIrq[irq_map_pkg::IRQ_RTC] = srcReq.rtcAlarmA | srcReq.rtcWakeup
                                   | (|srcReq.rtcTamper);
    rawIrq[irq_map_pkg::IRQ_VOLTAGE] = srcReq.voltageDetectorIrq;
    rawIrq[irq_map_pkg::IRQ_PORT_B] = srcReq.portBPinIrq;
    rawIrq[irq_map_pkg::IRQ_PORT_D] = srcReq.portDPinIrq;
    rawIrq[irq_map_pkg::IRQ_CLOCK] = srcReq.clockSwitchIrq
                                     | srcReq.clockSecurityFault;
    rawIrq[irq_map_pkg::IRQ_ADC] = srcReq.adcUnitOneIrq;
    rawIrq[irq_map_pkg::IRQ_RESERVED] = 1'b0;
  end

  logic [7:0] rawIrqLine;

  // One entry per external line, fixed four-byte vector steps
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gLine
      assign rawIrqLine[g] = srcReq.extLineIrq[g];
    end
  endgenerate

  logic [irq_map_pkg::NUM_IRQ-1:0] allIrq;
  logic [irq_map_pkg::NUM_IRQ-1:0] enabledIrq;

  assign allIrq = rawIrq | ({{(irq_map_pkg::NUM_IRQ-16){1'b0}}, rawIrqLine, 8'h00});
  assign enabledIrq = allIrq & irqEnable;

  // ------------------------------------------------------------------
  // Wake masks per mode
  // ------------------------------------------------------------------
  logic [irq_map_pkg::NUM_IRQ-1:0] wakeMask;

  always_comb begin
    case (powerMode)
      irq_map_pkg::MODE_HALT: wakeMask = irq_map_pkg::WAKE_HALT_MASK;
      irq_map_pkg::MODE_ACTIVE_HALT: wakeMask = irq_map_pkg::WAKE_ACTIVE_HALT_MASK;
      irq_map_pkg::MODE_INT_WAIT: wakeMask = irq_map_pkg::WAKE_INT_WAIT_MASK;
      irq_map_pkg::MODE_EVT_WAIT: wakeMask = irq_map_pkg::WAKE_EVT_WAIT_MASK;
      default: wakeMask = '1;
    endcase
  end

  // ------------------------------------------------------------------
  // Selection of the presented IRQ
  // ------------------------------------------------------------------
  logic pickFound;
  logic [irq_map_pkg::IRQ_W-1:0] pickNum;
  logic [irq_map_pkg::NUM_IRQ-1:0] eligible;

  // In low-power modes only sources allowed to wake may be presented
  assign eligible = enabledIrq & wakeMask;

  irq_priority_pick uPick (
    .pending(eligible),
    .found(pickFound),
    .winner(pickNum)
  );

  function automatic logic [irq_map_pkg::VEC_W-1:0] vecOf(
    input logic [irq_map_pkg::IRQ_W-1:0] n
  );
    vecOf = irq_map_pkg::IRQ_VECTOR_BASE
            + irq_map_pkg::VEC_W'({n, 2'b00});
  endfunction : vecOf

  // Registered answer; held while the core has not yet taken it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vecOut <= '0;
    end else if (!vecOut.valid || vecTaken) begin
      vecOut.valid <= pickFound;
      vecOut.irqNum <= pickNum;
      vecOut.vector <= vecOf(pickNum);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqPending <= '0;
    end else begin
      irqPending <= allIrq;
    end
  end

  // ------------------------------------------------------------------
  // Wakeup decisions
  // ------------------------------------------------------------------
  logic inLowPower;
  logic evtServe;
  logic evtResume;

  assign inLowPower = (powerMode != irq_map_pkg::MODE_RUN);
  // Event wait: enabled irq is served and sleep resumes; a wake event resumes run
  assign evtServe = (powerMode == irq_map_pkg::MODE_EVT_WAIT)
                    && |(enabledIrq & wakeMask & ~wakeEventCfg);
  assign evtResume = (powerMode == irq_map_pkg::MODE_EVT_WAIT)
                     && |(allIrq & wakeMask & wakeEventCfg);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wakeReq <= 1'b0;
      resumeReq <= 1'b0;
      returnToEventWait <= 1'b0;
    end else begin
      wakeReq <= inLowPower && (|eligible || evtResume);
      resumeReq <= evtResume;
      returnToEventWait <= evtServe && !evtResume;
    end
  end

  // Fixed vectors: reset wakes every mode through the reset path itself
  assign resetVector = irq_map_pkg::RESET_VECTOR;
  assign trapVector = irq_map_pkg::TRAP_VECTOR;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_reserved_never;
    @(posedge clk) disable iff (sys_rst)
      !irqPending[irq_map_pkg::IRQ_RESERVED];
  endproperty
  a_reserved_never: assert property (p_reserved_never)
    else $error("reserved irq raised");

  property p_top_level_or;
    @(posedge clk) disable iff (sys_rst)
      (generalTimerAOverflow || basicEightBitTimerOverflow) |=> irqPending[0];
  endproperty
  a_top_level_or: assert property (p_top_level_or)
    else $error("top-level irq not raised by timer overflow");

  property p_vector_step;
    @(posedge clk) disable iff (sys_rst)
      vecOut.valid |-> vecOut.vector == 24'h008008 + {17'h0, vecOut.irqNum, 2'b00};
  endproperty
  a_vector_step: assert property (p_vector_step)
    else $error("vector address does not match irq number");

  property p_no_wake_top_level;
    @(posedge clk) disable iff (sys_rst)
      (inLowPower && allIrq == 19'h00001 && wakeEventCfg == '0) |=> !wakeReq;
  endproperty
  a_no_wake_top_level: assert property (p_no_wake_top_level)
    else $error("top-level irq woke device");

  property p_flash_halt;
    @(posedge clk) disable iff (sys_rst)
      (powerMode == irq_map_pkg::MODE_HALT && allIrq == 19'h00002) |=> !wakeReq;
  endproperty
  a_flash_halt: assert property (p_flash_halt)
    else $error("flash irq woke from halt");

  property p_dma_wait;
    @(posedge clk) disable iff (sys_rst)
      (powerMode == irq_map_pkg::MODE_INT_WAIT && irqEnable[3] && srcReq.dmaUnitOneIrq[2])
      |=> wakeReq;
  endproperty
  a_dma_wait: assert property (p_dma_wait)
    else $error("dma 2/3 did not wake from wait");

  property p_line_halt;
    @(posedge clk) disable iff (sys_rst)
      (powerMode == irq_map_pkg::MODE_HALT && |(srcReq.extLineIrq & irqEnable[15:8]))
      |=> wakeReq;
  endproperty
  a_line_halt: assert property (p_line_halt)
    else $error("external line did not wake from halt");

  property p_clock_halt;
    @(posedge clk) disable iff (sys_rst)
      (powerMode == irq_map_pkg::MODE_ACTIVE_HALT && allIrq == 19'h20000) |=> !wakeReq;
  endproperty
  a_clock_halt: assert property (p_clock_halt)
    else $error("clock irq woke from active halt");

  property p_lowest_first;
    @(posedge clk) disable iff (sys_rst)
      (!vecOut.valid && eligible[1] && eligible[0]) |=> vecOut.irqNum == 5'h00;
  endproperty
  a_lowest_first: assert property (p_lowest_first)
    else $error("lower irq not presented first");

  property p_adc_halt;
    @(posedge clk) disable iff (sys_rst)
      (powerMode == irq_map_pkg::MODE_HALT && irqEnable[18] && srcReq.adcUnitOneIrq)
      |=> wakeReq;
  endproperty
  a_adc_halt: assert property (p_adc_halt)
    else $error("converter did not wake from halt");

  property p_flash_wait;
    @(posedge clk) disable iff (sys_rst)
      (powerMode == irq_map_pkg::MODE_INT_WAIT && irqEnable[1] && srcReq.flashIrq)
      |=> wakeReq;
  endproperty
  a_flash_wait: assert property (p_flash_wait)
    else $error("flash irq did not wake from interrupt wait");

  property p_dma01_halt;
    @(posedge clk) disable iff (sys_rst)
      (powerMode == irq_map_pkg::MODE_HALT && allIrq == 19'h00004) |=> !wakeReq;
  endproperty
  a_dma01_halt: assert property (p_dma01_halt)
    else $error("dma 0/1 irq woke from halt");

  property p_rtc_active_halt;
    @(posedge clk) disable iff (sys_rst)
      (powerMode == irq_map_pkg::MODE_ACTIVE_HALT && irqEnable[4] && srcReq.rtcWakeup)
      |=> wakeReq;
  endproperty
  a_rtc_active_halt: assert property (p_rtc_active_halt)
    else $error("clock wakeup did not wake from active halt");

  property p_port_d_halt;
    @(posedge clk) disable iff (sys_rst)
      (powerMode == irq_map_pkg::MODE_HALT && irqEnable[7] && srcReq.portDPinIrq)
      |=> wakeReq;
  endproperty
  a_port_d_halt: assert property (p_port_d_halt)
    else $error("port d pin did not wake from halt");

  property p_resume_evt;
    @(posedge clk) disable iff (sys_rst)
      (powerMode == irq_map_pkg::MODE_EVT_WAIT && srcReq.voltageDetectorIrq && wakeEventCfg[5])
      |=> resumeReq && !returnToEventWait;
  endproperty
  a_resume_evt: assert property (p_resume_evt)
    else $error("wake event did not resume");

  property p_evt_return;
    @(posedge clk) disable iff (sys_rst)
      (powerMode == irq_map_pkg::MODE_EVT_WAIT && irqEnable[6] && srcReq.portBPinIrq
       && wakeEventCfg == '0) |=> returnToEventWait;
  endproperty
  a_evt_return: assert property (p_evt_return)
    else $error("served irq did not return to event wait");

  // A presented vector must not move until the core has taken it
  property p_vec_hold;
    @(posedge clk) disable iff (sys_rst)
      (vecOut.valid && !vecTaken) |=> $stable(vecOut);
  endproperty
  a_vec_hold: assert property (p_vec_hold)
    else $error("presented vector changed before it was taken");

  c_vec_taken: cover property (@(posedge clk) disable iff (sys_rst)
    vecOut.valid && vecTaken);
  c_evt_resume: cover property (@(posedge clk) disable iff (sys_rst) resumeReq);
  c_evt_return: cover property (@(posedge clk) disable iff (sys_rst) returnToEventWait);
  c_halt_wake: cover property (@(posedge clk) disable iff (sys_rst)
    powerMode == irq_map_pkg::MODE_HALT && wakeReq);
  c_line_vector: cover property (@(posedge clk) disable iff (sys_rst)
    vecOut.valid && vecOut.irqNum == irq_map_pkg::IRQ_LINE0);

endmodule : interrupt_vector_map

/* File: core_vector_fetch.sv */
/*
  Core-side model that fetches the vectors the map presents.
  Assumes vecOut is registered on clk; it waits fetchDelay cycles, then pulses vecTaken.
*/
`timescale 1ns/10ps
module core_vector_fetch (
  input wire logic clk,
  input wire logic sys_rst,
  input wire irq_map_pkg::vec_out_t vecOut,
  input wire logic [1:0] fetchDelay,
  output logic vecTaken
);
  logic [1:0] waitCnt_q;
  // Never acknowledges an empty slot, so each pulse pairs with exactly one vector
  always_ff @(posedge clk) begin
    vecTaken <= 1'b0;
    if (sys_rst) begin
      waitCnt_q <= 2'h0;
    end else if (vecOut.valid && !vecTaken) begin
      if (waitCnt_q >= fetchDelay) begin
        vecTaken <= 1'b1;
        waitCnt_q <= 2'h0;
      end else begin
        waitCnt_q <= waitCnt_q + 2'h1;
      end
    end
  end
endmodule : core_vector_fetch

/* File: interrupt_vector_map_tb.sv */
/*
  Self-checking bench for the interrupt vector map, with a scoreboard queue.
  Assumes core_vector_fetch as the core; one 200 MHz clock, synchronous reset.
*/
`timescale 1ns/10ps
module interrupt_vector_map_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  irq_map_pkg::src_req_t srcReq = '0;
  logic genOvf = 1'b0;
  logic basicOvf = 1'b0;
  logic [18:0] irqEnable = '0;
  logic [18:0] wakeEventCfg = '0;
  irq_map_pkg::power_mode_t powerMode = irq_map_pkg::MODE_RUN;
  logic [1:0] fetchDelay = 2'h0;
  logic vecTaken;
  irq_map_pkg::vec_out_t vecOut;
  logic [18:0] irqPending;
  logic wakeReq;
  logic resumeReq;
  logic returnToEventWait;
  logic [23:0] resetVector;
  logic [23:0] trapVector;
  logic [28:0] expQ[$];
  logic [31:0] rnd = 32'h26cabbce;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  interrupt_vector_map uut (.clk(clk), .sys_rst(sys_rst), .srcReq(srcReq),
    .generalTimerAOverflow(genOvf), .basicEightBitTimerOverflow(basicOvf),
    .irqEnable(irqEnable), .wakeEventCfg(wakeEventCfg), .powerMode(powerMode),
    .vecTaken(vecTaken), .vecOut(vecOut), .irqPending(irqPending), .wakeReq(wakeReq),
    .resumeReq(resumeReq), .returnToEventWait(returnToEventWait),
    .resetVector(resetVector), .trapVector(trapVector));
  core_vector_fetch core (.clk(clk), .sys_rst(sys_rst), .vecOut(vecOut),
    .fetchDelay(fetchDelay), .vecTaken(vecTaken));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // Eligible lines per mode, written out independently of the package masks
  function automatic logic [18:0] maskOf(input int m);
    return (m == 0) ? 19'h6ffff : (m < 3) ? 19'h4fff0 : 19'h6fffe;
  endfunction : maskOf

  // Shared lines pick one of their sources at random so each field gets hit
  function automatic irq_map_pkg::src_req_t buildReq(input logic [18:0] s, input logic [31:0] r);
    irq_map_pkg::src_req_t q;
    q = '0;
    q.flashIrq = s[1];
    q.dmaUnitOneIrq = {s[3] & r[1], s[3] & ~r[1], s[2] & r[0], s[2] & ~r[0]};
    q.rtcAlarmA = s[4] & (r[3:2] == 2'h0);
    q.rtcWakeup = s[4] & (r[3:2] == 2'h1);
    q.rtcTamper = {3{s[4] & r[3]}} & (3'h1 << ((r[5:4] == 2'h3) ? 2'h0 : r[5:4]));
    q.voltageDetectorIrq = s[5];
    q.portBPinIrq = s[6];
    q.portDPinIrq = s[7];
    q.extLineIrq = s[15:8];
    q.clockSwitchIrq = s[17] & r[6];
    q.clockSecurityFault = s[17] & ~r[6];
    q.adcUnitOneIrq = s[18];
    return q;
  endfunction : buildReq

  task automatic note(input logic bad, input string msg);
    samples_checked++;
    if (bad !== 1'b0) begin
      n_fail++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : note

  task automatic give_verdict();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // One-cycle request burst; only the lowest eligible line may be latched
  task automatic apply(input logic [18:0] s, input logic [18:0] en, input logic [18:0] cfg,
                       input int m);
    logic [18:0] elig;
    logic [18:0] wev;
    logic evt;
    int k;
    rnd = xorshift(rnd);
    elig = s & en & maskOf(m);
    evt = (m == 4);
    wev = evt ? (s & cfg & maskOf(m)) : 19'h0;
    @(posedge clk);
    srcReq <= buildReq(s, rnd);
    genOvf <= s[0] & rnd[7];
    basicOvf <= s[0] & ~rnd[7];
    irqEnable <= en;
    wakeEventCfg <= cfg;
    powerMode <= irq_map_pkg::power_mode_t'(m);
    fetchDelay <= rnd[9:8];
    for (k = 0; k < 19; k++) begin
      if (elig[k]) begin
        expQ.push_back({5'(k), 24'h008008 + 24'(4 * k)});
        break;
      end
    end
    @(posedge clk);
    srcReq <= '0;
    genOvf <= 1'b0;
    basicOvf <= 1'b0;
    #1;
    note(irqPending !== (s & 19'h6ffff), "raw lines");
    note(wakeReq !== (m != 0 && (elig | wev) != 0), "wake");
    note(resumeReq !== (wev != 0), "resume");
    note(returnToEventWait !== (evt && (elig & ~cfg) != 0 && wev == 0), "return");
    for (k = 0; k < 40 && expQ.size() != 0; k++) @(posedge clk);
    note(expQ.size() != 0, "vector not fetched");
    repeat (3) @(posedge clk);
    #1;
    note(vecOut.valid !== 1'b0, "stale vector");
  endtask : apply

  // ------------------------------------------------------------------
  // Scoreboard and timeout
  // ------------------------------------------------------------------
  always @(posedge clk) begin : watch
    logic [28:0] e;
    if (!sys_rst) note(irqPending[16] !== 1'b0, "reserved line");
    if (!sys_rst && vecOut.valid === 1'b1 && vecTaken === 1'b1) begin
      if (expQ.size() == 0) begin
        note(1'b1, "unexpected vector");
      end else begin
        e = expQ.pop_front();
        note({vecOut.irqNum, vecOut.vector} !== e, "vector");
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin : main
    int i;
    int j;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    note(resetVector !== 24'h008000 || trapVector !== 24'h008004, "fixed vectors");
    note(vecOut.valid !== 1'b0 || wakeReq !== 1'b0, "reset state");
    for (i = 0; i < 5; i++) begin
      for (j = 0; j < 19; j++) begin
        rnd = xorshift(rnd);
        apply(19'h1 << j, rnd[18:0] | (19'(rnd[19] | rnd[20]) << j), '0, i);
      end
    end
    for (i = 0; i < 30; i++) begin
      rnd = xorshift(rnd);
      apply(19'h1 << (4 + rnd[31:28] % 12), rnd[18:0], rnd[27:9], 4);
    end
    for (i = 0; i < 40; i++) begin
      rnd = xorshift(rnd);
      j = rnd[31:29] % 5;
      apply(rnd[18:0], 19'(xorshift(rnd)) | 19'h7f0f0, (j == 4) ? rnd[28:10] : '0, j);
    end
    give_verdict();
  end
endmodule : interrupt_vector_map_tb
